// *** adssr_pkg.sv ***
// Constants and state types of the decoder status and stream register slice.
// Assumes an 8-bit register port with read data one cycle after the strobe.
package adssr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_EV = 5;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_STREAM  = 8'hac;
  localparam logic [ADDR_W-1:0] ADDR_REQSTA  = 8'haf;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'hc8;
  localparam logic [ADDR_W-1:0] ADDR_IRQSTAT = 8'hd0;
  localparam logic [ADDR_W-1:0] ADDR_IRQCLR  = 8'hd1;
  localparam logic [ADDR_W-1:0] ADDR_IRQEN   = 8'hd2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'hd3;

  // Field positions of decoder_status_flags; interrupt registers share bits 7..3
  localparam int unsigned STA_ANC_BIT  = 7;
  localparam int unsigned STA_REQ_BIT  = 6;
  localparam int unsigned STA_LAY_BIT  = 5;
  localparam int unsigned STA_SYN_BIT  = 4;
  localparam int unsigned STA_CRC_BIT  = 3;
  localparam int unsigned STA_RATE_LSB = 1;
  localparam int unsigned STA_VER_BIT  = 0;
  localparam int unsigned EV_LSB       = 3;

  // Field positions of decoder_request_status
  localparam int unsigned REQ_FRAME_BIT = 4;
  localparam int unsigned REQ_BYTE_BIT  = 3;
  localparam int unsigned REQ_BOOT_BIT  = 0;

  // Field position of the control register
  localparam int unsigned CTRL_PLAYCRC_BIT = 0;

  // Values after reset
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h01;
  localparam logic [DATA_W-1:0] REQSTA_RST = 8'h11;
  localparam logic [DATA_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [NUM_EV-1:0] IRQEN_RST  = 5'h00;
  localparam logic [1:0]        RATE_RSVD  = 2'h3;

  typedef struct packed {
    logic              anc;
    logic              dataReq;
    logic              layErr;
    logic              synErr;
    logic              crcErr;
    logic [1:0]        rate;
    logic              ver;
    logic              frameReq;
    logic              bootBit;
    logic [NUM_EV-1:0] irqStat;
    logic [NUM_EV-1:0] irqEn;
    logic              playBadCrc;
    logic              reqPrev;
    logic              ancPrev;
    logic [DATA_W-1:0] rdData;
    logic              irq;
    logic              skipFrame;
  } adssr_main_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              pending;
    logic              byteReq;
  } adssr_stream_t;

  localparam adssr_main_t MAIN_RST = '{
    anc:        STATUS_RST[STA_ANC_BIT],
    dataReq:    STATUS_RST[STA_REQ_BIT],
    layErr:     STATUS_RST[STA_LAY_BIT],
    synErr:     STATUS_RST[STA_SYN_BIT],
    crcErr:     STATUS_RST[STA_CRC_BIT],
    rate:       STATUS_RST[STA_RATE_LSB +: 2],
    ver:        STATUS_RST[STA_VER_BIT],
    frameReq:   REQSTA_RST[REQ_FRAME_BIT],
    bootBit:    REQSTA_RST[REQ_BOOT_BIT],
    irqStat:    '0,
    irqEn:      IRQEN_RST,
    playBadCrc: CTRL_RST[CTRL_PLAYCRC_BIT],
    reqPrev:    1'b0,
    ancPrev:    1'b0,
    rdData:     '0,
    irq:        1'b0,
    skipFrame:  1'b0
  };

  localparam adssr_stream_t STREAM_RST = '{
    data:    '0,
    pending: 1'b0,
    byteReq: REQSTA_RST[REQ_BYTE_BIT]
  };

endpackage

// *** adssr_stream_if.sv ***
// Link between the register slice and its stream input holder.
// Both ends run on the same clock; no crossing.
`timescale 1ns/1ps
`default_nettype none
interface adssr_stream_if;
  import adssr_pkg::*;
  logic              wrStrobe;
  logic [DATA_W-1:0] wrByte;
  logic              decReq;
  logic              byteTaken;
  logic [DATA_W-1:0] byteData;
  logic              byteValid;
  logic              byteReq;

  modport regs (
    output wrStrobe, wrByte, decReq, byteTaken,
    input  byteData, byteValid, byteReq
  );
  modport unit (
    input  wrStrobe, wrByte, decReq, byteTaken,
    output byteData, byteValid, byteReq
  );
endinterface
`default_nettype wire

// *** adssr_stream_in.sv ***
// One-byte holder for the compressed stream and the byte-level request flag.
// Assumes the decoder pulses byteTaken for one cycle when it consumes the byte.
`timescale 1ns/1ps
`default_nettype none
module adssr_stream_in
  import adssr_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // Register slice side
  adssr_stream_if.unit sif
);

  adssr_stream_t s_r;
  adssr_stream_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (sif.wrStrobe) begin
      s_nxt.data    = sif.wrByte;
      s_nxt.pending = 1'b1;
    end else if (sif.byteTaken) begin
      s_nxt.pending = 1'b0;
    end
    // Only one byte is held, so the request stays down until it is consumed
    s_nxt.byteReq = sif.decReq & ~s_nxt.pending;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= STREAM_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sif.byteData  = s_r.data;
  assign sif.byteValid = s_r.pending;
  assign sif.byteReq   = s_r.byteReq;

endmodule
`default_nettype wire

// *** adssr_regs.sv ***
// Decoder status and stream input registers with their interrupt logic.
// Assumes decoder inputs come from logic on clk and need no synchroniser.
`timescale 1ns/1ps
`default_nettype none
module adssr_regs
  import adssr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  // Decoder events and frame information
  input  wire logic              ancAvail,
  input  wire logic              decReq,
  input  wire logic              layerErr,
  input  wire logic              syncErr,
  input  wire logic              crcErr,
  input  wire logic              hdrValid,
  input  wire logic              hdrVersion,
  input  wire logic [1:0]        hdrRate,
  // Stream towards the decoder
  input  wire logic              byteTaken,
  output logic      [DATA_W-1:0] streamByte,
  output logic                   streamValid,
  // Decoder control
  output logic                   playBadCrc,
  output logic                   skipFrame,
  // Interrupt
  output logic                   irq
);

  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    hit = (addr == off);
  endfunction

  // Event bits in the order of status bits 7..3
  function automatic logic [NUM_EV-1:0] evPack(
    input logic a,
    input logic r,
    input logic l,
    input logic s,
    input logic c
  );
    evPack = {a, r, l, s, c};
  endfunction

  adssr_main_t s_r;
  adssr_main_t s_nxt;

  adssr_stream_if sif ();

  adssr_stream_in u_stream (
    .clk (clk),
    .rst (rst),
    .sif (sif)
  );

  logic              wrStream;
  logic              rdStatus;
  logic              reqRise;
  logic              ancRise;
  logic [NUM_EV-1:0] events;
  logic [DATA_W-1:0] statusVal;
  logic [DATA_W-1:0] reqStaVal;
  logic [DATA_W-1:0] irqStatVal;
  logic [DATA_W-1:0] irqEnVal;
  logic [DATA_W-1:0] ctrlVal;

  assign wrStream = regWr & hit(regAddr, ADDR_STREAM);
  assign rdStatus = regRd & hit(regAddr, ADDR_STATUS);

  // The request flag marks a new demand, not every cycle of it
  assign reqRise = decReq & ~s_r.reqPrev;
  assign ancRise = ancAvail & ~s_r.ancPrev;
  assign events  = evPack(ancRise, reqRise, layerErr, syncErr, crcErr);

  assign sif.wrStrobe  = wrStream;
  assign sif.wrByte    = regWrData;
  assign sif.decReq    = decReq;
  assign sif.byteTaken = byteTaken;

  always_comb begin
    statusVal                        = '0;
    statusVal[STA_ANC_BIT]           = s_r.anc;
    statusVal[STA_REQ_BIT]           = s_r.dataReq;
    statusVal[STA_LAY_BIT]           = s_r.layErr;
    statusVal[STA_SYN_BIT]           = s_r.synErr;
    statusVal[STA_CRC_BIT]           = s_r.crcErr;
    statusVal[STA_RATE_LSB +: 2]     = s_r.rate;
    statusVal[STA_VER_BIT]           = s_r.ver;
  end

  always_comb begin
    reqStaVal                = '0;
    reqStaVal[REQ_FRAME_BIT] = s_r.frameReq;
    reqStaVal[REQ_BYTE_BIT]  = sif.byteReq;
    reqStaVal[REQ_BOOT_BIT]  = s_r.bootBit;
  end

  always_comb begin
    irqStatVal                          = '0;
    irqStatVal[EV_LSB +: NUM_EV]        = s_r.irqStat;
    irqEnVal                            = '0;
    irqEnVal[EV_LSB +: NUM_EV]          = s_r.irqEn;
    ctrlVal                             = '0;
    ctrlVal[CTRL_PLAYCRC_BIT]           = s_r.playBadCrc;
  end

  always_comb begin
    s_nxt = s_r;

    s_nxt.reqPrev = decReq;
    s_nxt.ancPrev = ancAvail;

    // Level copy of the ancillary buffer state, never touched by reads
    s_nxt.anc = ancAvail;

    // Clear only when the flag was in the value returned; a new event wins
    s_nxt.dataReq = (s_r.dataReq & ~(rdStatus & s_r.dataReq))
                  | reqRise;
    s_nxt.layErr  = (s_r.layErr & ~(rdStatus & s_r.layErr))
                  | layerErr;
    s_nxt.synErr  = (s_r.synErr & ~(rdStatus & s_r.synErr))
                  | syncErr;
    s_nxt.crcErr  = (s_r.crcErr & ~(rdStatus & s_r.crcErr))
                  | crcErr;

    // A reserved rate code keeps the last valid frame information
    if (hdrValid && (hdrRate != RATE_RSVD)) begin
      s_nxt.ver  = hdrVersion;
      s_nxt.rate = hdrRate;
    end

    s_nxt.frameReq = decReq;

    // Reset marker in the low request bit drops at the first stream byte
    if (wrStream) begin
      s_nxt.bootBit = 1'b0;
    end

    // Interrupt status: write-one-to-clear, a same-cycle event stays set
    s_nxt.irqStat = s_r.irqStat | events;
    if (regWr && hit(regAddr, ADDR_IRQCLR)) begin
      s_nxt.irqStat = (s_r.irqStat & ~regWrData[EV_LSB +: NUM_EV]) | events;
    end

    if (regWr && hit(regAddr, ADDR_IRQEN)) begin
      s_nxt.irqEn = regWrData[EV_LSB +: NUM_EV];
    end

    if (regWr && hit(regAddr, ADDR_CTRL)) begin
      s_nxt.playBadCrc = regWrData[CTRL_PLAYCRC_BIT];
    end

    s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqEn);

    // Tell the decoder to drop a bad frame unless playback is requested
    s_nxt.skipFrame = crcErr & ~s_r.playBadCrc;

    // Writes to the status address fall through here unchanged
    s_nxt.rdData = '0;
    if (regRd) begin
      case (regAddr)
        ADDR_STATUS: begin
          s_nxt.rdData = statusVal;
        end
        ADDR_REQSTA: begin
          s_nxt.rdData = reqStaVal;
        end
        ADDR_IRQSTAT: begin
          s_nxt.rdData = irqStatVal;
        end
        ADDR_IRQEN: begin
          s_nxt.rdData = irqEnVal;
        end
        ADDR_CTRL: begin
          s_nxt.rdData = ctrlVal;
        end
        default: begin
          s_nxt.rdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= MAIN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData   = s_r.rdData;
  assign irq         = s_r.irq;
  assign playBadCrc  = s_r.playBadCrc;
  assign skipFrame   = s_r.skipFrame;
  assign streamByte  = sif.byteData;
  assign streamValid = sif.byteValid;

endmodule
`default_nettype wire

// *** adssr_regs_properties.sv ***
// Port checks for the decoder status and stream register slice.
// Assumes decoder inputs stay low while reset is held.
`timescale 1ns/1ps
`default_nettype none
module adssr_regs_properties
  import adssr_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  // Decoder side
  input wire logic       ancAvail,
  input wire logic       decReq,
  input wire logic       layerErr,
  input wire logic       syncErr,
  input wire logic       crcErr,
  input wire logic       hdrValid,
  input wire logic       hdrVersion,
  input wire logic [1:0] hdrRate,
  input wire logic       byteTaken,
  input wire logic [7:0] streamByte,
  input wire logic       streamValid,
  input wire logic       playBadCrc,
  input wire logic       skipFrame
);
  logic rdSta;
  logic rdReq;
  logic wrStr;
  assign rdSta = regRd && regAddr == ADDR_STATUS;
  assign rdReq = regRd && regAddr == ADDR_REQSTA;
  assign wrStr = regWr && regAddr == ADDR_STREAM;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_anc_follow: assert property (rdSta && !$past(rst)
    |=> regRdData[7] == $past(ancAvail, 2)) else $error("anc flag wrong");
  chk_frame_req: assert property (rdReq && !$past(rst)
    |=> regRdData[4] == $past(decReq, 2)) else $error("frame req wrong");
  chk_rsvd_zero: assert property (rdReq
    |=> regRdData[7:5] == 3'h0 && regRdData[2:1] == 2'h0) else $error("reserved set");
  chk_err_sticky: assert property (crcErr ##1 rdSta
    |=> regRdData[3]) else $error("crc flag lost");
  chk_read_clears: assert property (rdSta && !layerErr && !syncErr && !crcErr
    ##1 rdSta |=> regRdData[5:3] == 3'h0) else $error("flags not cleared");
  chk_set_wins: assert property (rdSta && syncErr ##1 rdSta
    |=> regRdData[4]) else $error("event lost on read");
  chk_byte_clear: assert property (wrStr ##1 rdReq
    |=> !regRdData[3]) else $error("byte req kept");
  chk_stream_load: assert property (wrStr
    |=> streamValid && streamByte == $past(regWrData)) else $error("byte not loaded");
  chk_stream_hold: assert property (streamValid && !byteTaken && !wrStr
    |=> streamValid && $stable(streamByte)) else $error("byte not held");
  chk_skip_frame: assert property (!$past(rst)
    |-> skipFrame == $past(crcErr && !playBadCrc)) else $error("skip wrong");
  chk_hdr_info: assert property (hdrValid && hdrRate != RATE_RSVD ##1 rdSta
    |=> regRdData[2:0] == {$past(hdrRate, 2), $past(hdrVersion, 2)}) else $error("hdr wrong");

  cover property (rdSta && syncErr);
  cover property (wrStr ##1 rdReq);
  cover property (skipFrame);
endmodule

bind adssr_regs adssr_regs_properties chkU (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .ancAvail(ancAvail), .decReq(decReq),
  .layerErr(layerErr), .syncErr(syncErr), .crcErr(crcErr), .hdrValid(hdrValid),
  .hdrVersion(hdrVersion), .hdrRate(hdrRate), .byteTaken(byteTaken),
  .streamByte(streamByte), .streamValid(streamValid), .playBadCrc(playBadCrc),
  .skipFrame(skipFrame)
);
`default_nettype wire

// *** adssr_dec_model.sv ***
// Decoder side model: consumes the held stream byte after a set delay.
// Assumes streamValid drops the cycle after byteTaken.
`timescale 1ns/1ps
`default_nettype none
module adssr_dec_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Stream in
  input  wire logic       streamValid,
  input  wire logic [7:0] streamByte,
  output logic            byteTaken,
  // Delay and last byte consumed
  input  wire logic [3:0] lat,
  output logic      [7:0] lastByte
);
  logic [3:0] waitCnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      byteTaken <= 1'b0;
      waitCnt <= 4'h0;
      lastByte <= 8'h00;
    end else begin
      byteTaken <= 1'b0;
      // One byte at a time, never twice for the same hold
      if (streamValid && !byteTaken) begin
        waitCnt <= (waitCnt == lat) ? 4'h0 : waitCnt + 4'h1;
        if (waitCnt == lat) begin
          byteTaken <= 1'b1;
          lastByte <= streamByte;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** audio_decoder_status_stream_regs_tb.sv ***
// Bench for the decoder status and stream register slice.
// Assumes the decoder model above on the stream side.
`timescale 1ns/1ps
`default_nettype none
module audio_decoder_status_stream_regs_tb;
  import adssr_pkg::*;
  logic clk, rst, regWr, regRd, ancAvail, decReq, layerErr, syncErr, crcErr;
  logic hdrValid, hdrVersion, byteTaken, streamValid, playBadCrc, skipFrame, irq;
  logic [1:0] hdrRate;
  logic [3:0] lat;
  logic [7:0] regAddr, regWrData, regRdData, streamByte, lastByte, d;
  int error_cnt, cmp_count;

  adssr_regs dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .ancAvail(ancAvail),
    .decReq(decReq), .layerErr(layerErr), .syncErr(syncErr), .crcErr(crcErr),
    .hdrValid(hdrValid), .hdrVersion(hdrVersion), .hdrRate(hdrRate),
    .byteTaken(byteTaken), .streamByte(streamByte), .streamValid(streamValid),
    .playBadCrc(playBadCrc), .skipFrame(skipFrame), .irq(irq));
  adssr_dec_model decU (.clk(clk), .rst(rst), .streamValid(streamValid),
    .streamByte(streamByte), .byteTaken(byteTaken), .lat(lat), .lastByte(lastByte));

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Strobes start just after an edge, so calls in a row run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask
  // Read, with error events {layer,sync,crc} raised in the strobe cycle
  task automatic rd(input logic [7:0] a, input logic [2:0] m);
    regRd <= 1'b1;
    regAddr <= a;
    {layerErr, syncErr, crcErr} <= m;
    @(posedge clk);
    regRd <= 1'b0;
    {layerErr, syncErr, crcErr} <= 3'h0;
    #1 d = regRdData;
  endtask
  task automatic ev(input logic [2:0] m);
    {layerErr, syncErr, crcErr} <= m;
    @(posedge clk);
    {layerErr, syncErr, crcErr} <= 3'h0;
    #1;
  endtask
  // Looks off the edge so a byte loaded at this edge is already visible
  task automatic waitByte(input logic [7:0] v);
    for (int i = 0; i < 30 && streamValid !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (streamValid !== 1'b0) begin
      error_cnt++;
      conclude();
    end
    chk("consumed", lastByte, v);
  endtask
  task automatic sendByte(input logic [7:0] v);
    wr(ADDR_STREAM, v);
    waitByte(v);
  endtask

  task automatic t_reset();
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
    chk("reqsta rst", d, 8'h11);
    rd(ADDR_STATUS, 3'h0);
    chk("status rst", d, 8'h01);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 3'h0);
    chk("status ro", d, 8'h01);
    rd(8'h10, 3'h0);
    chk("unmapped", d, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_errors();
    ev(3'h7);
    rd(ADDR_STATUS, 3'h2);
    chk("errors", d, 8'h39);
    rd(ADDR_STATUS, 3'h0);
    chk("same cycle", d, 8'h11);
    rd(ADDR_STATUS, 3'h0);
    chk("cleared", d, 8'h01);
    $display("error test done");
  endtask
  task automatic t_header();
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        hdrValid <= 1'b1;
        hdrVersion <= v[0];
        hdrRate <= c[1:0];
        @(posedge clk);
        hdrValid <= 1'b0;
        rd(ADDR_STATUS, 3'h0);
        chk("hdr", {5'h0, d[2:0]}, (c == 3) ? 8'h05 : {5'h0, c[1:0], v[0]});
      end
    end
    $display("header test done");
  endtask
  task automatic t_stream();
    lat <= 4'h4;
    decReq <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, 3'h0);
    chk("req flag", {7'h0, d[6]}, 8'h01);
    rd(ADDR_STATUS, 3'h0);
    chk("req read", {7'h0, d[6]}, 8'h00);
    rd(ADDR_REQSTA, 3'h0);
    chk("reqsta", d & 8'hfe, 8'h18);
    wr(ADDR_STREAM, 8'ha5);
    rd(ADDR_REQSTA, 3'h0);
    chk("byte req", d, 8'h10);
    waitByte(8'ha5);
    sendByte(8'h5a);
    repeat (2) @(posedge clk);
    rd(ADDR_REQSTA, 3'h0);
    chk("byte back", d, 8'h18);
    lat <= 4'h0;
    sendByte(8'h3c);
    decReq <= 1'b0;
    repeat (2) @(posedge clk);
    rd(ADDR_REQSTA, 3'h0);
    chk("no req", d & 8'hf8, 8'h00);
    $display("stream test done");
  endtask
  task automatic t_anc();
    ancAvail <= 1'b1;
    rd(ADDR_STATUS, 3'h0);
    rd(ADDR_STATUS, 3'h0);
    chk("anc", {7'h0, d[7]}, 8'h01);
    ancAvail <= 1'b0;
    rd(ADDR_STATUS, 3'h0);
    rd(ADDR_STATUS, 3'h0);
    chk("anc off", {7'h0, d[7]}, 8'h00);
    $display("ancillary test done");
  endtask
  task automatic t_irq_crc();
    // Earlier tests left events behind; start from a clean status
    wr(ADDR_IRQCLR, 8'hf8);
    wr(ADDR_IRQEN, 8'h08);
    chk("irq idle", {7'h0, irq}, 8'h00);
    ev(3'h1);
    chk("irq on", {7'h0, irq}, 8'h01);
    chk("skip", {7'h0, skipFrame}, 8'h01);
    wr(ADDR_IRQCLR, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk("irq clr", {7'h0, irq}, 8'h00);
    wr(ADDR_IRQEN, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    ev(3'h1);
    chk("irq mask", {7'h0, irq}, 8'h00);
    chk("play", {6'h0, playBadCrc, skipFrame}, 8'h02);
    rd(ADDR_IRQSTAT, 3'h0);
    chk("irq stat", d, 8'h08);
    rd(ADDR_IRQEN, 3'h0);
    chk("irq en", d, 8'h00);
    rd(ADDR_CTRL, 3'h0);
    chk("ctrl", d, 8'h01);
    $display("irq test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, regWr, regRd, ancAvail, decReq, layerErr, syncErr, crcErr} = 8'hff & 8'h80;
    {hdrValid, hdrVersion, hdrRate, lat, regAddr, regWrData} = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // First read rides on the release edge, before bit 4 follows decReq
    regRd <= 1'b1;
    regAddr <= ADDR_REQSTA;
    t_reset();
    t_errors();
    t_header();
    t_stream();
    t_anc();
    t_irq_crc();
    conclude();
  end
endmodule
`default_nettype wire
